//--- mmuc_regs.svh
`ifndef MMUC_REGS_SVH
`define MMUC_REGS_SVH
// ----------------------------------------
// Control word select field
// ----------------------------------------
`define MMUC_SEL_HI 7
`define MMUC_SEL_LO 6
// ----------------------------------------
// Master control bits
// ----------------------------------------
`define MMUC_MC_PTR_CLR 0
`define MMUC_MC_LATCH 1
`define MMUC_MC_TOG_CLR 2
`define MMUC_MC_LOAD 3
`define MMUC_MC_MATCH_CLR 4
`define MMUC_MC_MRESET 5
// ----------------------------------------
// Input control bits
// ----------------------------------------
`define MMUC_IC_DIRMODE 0
`define MMUC_IC_STEP_UP 1
`define MMUC_IC_STEP_DN 2
`define MMUC_IC_AB_EN 3
`define MMUC_IC_GATE_ROLE 4
`define MMUC_IC_LOAD_ROLE 5
// ----------------------------------------
// Output/counter control bits
// ----------------------------------------
`define MMUC_OC_BCD 0
`define MMUC_OC_ONCE 1
`define MMUC_OC_DIVN 2
`define MMUC_OC_CLOCK 3
`define MMUC_OC_ROUTE_LO 4
`define MMUC_OC_ROUTE_HI 5
// ----------------------------------------
// Quadrature control and status bits
// ----------------------------------------
`define MMUC_QC_EN0 0
`define MMUC_QC_EN1 1
`define MMUC_ST_UNDER 0
`define MMUC_ST_OVER 1
`define MMUC_ST_MATCH 2
`define MMUC_ST_SIGN 3
`define MMUC_ST_UP 4
// ----------------------------------------
// Values
// ----------------------------------------
`define MMUC_PRESET_RST 24'hffffff
`define MMUC_BIN_MAX 24'hffffff
`define MMUC_BCD_MAX 24'h999999
`define MMUC_CLOCK_MAX 24'h235959
`define MMUC_CLOCK_LIM 24'h295959
`define MMUC_LAST_BYTE 2'h2
`define MMUC_CTL_RST 6'h00
`endif

//--- mmuc_pkg.sv
`default_nettype none
package mmuc_pkg;
  typedef enum logic [1:0] {MMUC_SEL_MASTER, MMUC_SEL_INPUT, MMUC_SEL_OUTCNT, MMUC_SEL_QUAD} mmuc_sel_e;
  typedef enum logic [1:0] {MMUC_CODE_BIN, MMUC_CODE_BCD, MMUC_CODE_CLOCK} mmuc_code_e;
  typedef enum logic [1:0] {MMUC_ROUTE_PULSE_LO, MMUC_ROUTE_TOGGLE, MMUC_ROUTE_PULSE_HI, MMUC_ROUTE_COMPARE}
    mmuc_route_e;
  typedef logic [23:0] mmuc_count_t;
endpackage
`default_nettype wire

//--- mmuc_cnt_if.sv
`default_nettype none
interface mmuc_cnt_if;
  logic a;
  logic b;
  logic quad_en;
  logic dir_mode;
  logic up;
  logic dn;
  logic quad_up;
  modport dec(input a, input b, input quad_en, input dir_mode, output up, output dn, output quad_up);
  modport core(output a, output b, output quad_en, output dir_mode, input up, input dn, input quad_up);
endinterface
`default_nettype wire

//--- mmuc_count_decode.sv
`default_nettype none
module mmuc_count_decode
  import mmuc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_sync_n,
  mmuc_cnt_if.dec cnt
);
  logic a_prev_reg;
  logic b_prev_reg;
  logic primed_reg;
  logic dir_reg;
  logic a_chg;
  logic b_chg;
  logic q_up;
  logic q_dn;

  // ----------------------------------------
  // Edge history
  // ----------------------------------------
  // First cycle after reset only primes history, no false edge
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      a_prev_reg <= cnt.a;
      b_prev_reg <= cnt.b;
      primed_reg <= 1'b1;
    end
  end

  assign a_chg = primed_reg & (cnt.a ^ a_prev_reg);
  assign b_chg = primed_reg & (cnt.b ^ b_prev_reg);
  // Both phases moving at once is ambiguous and dropped
  assign q_up = (a_chg & ~b_chg & (cnt.a != cnt.b)) | (b_chg & ~a_chg & (cnt.a == cnt.b));
  assign q_dn = (a_chg & ~b_chg & (cnt.a == cnt.b)) | (b_chg & ~a_chg & (cnt.a != cnt.b));

  always_comb begin
    if (cnt.quad_en) begin
      cnt.up = q_up;
      cnt.dn = q_dn;
    end else if (cnt.dir_mode) begin
      cnt.up = a_chg & cnt.a & ~cnt.b;
      cnt.dn = a_chg & cnt.a & cnt.b;
    end else begin
      cnt.up = a_chg & cnt.a;
      cnt.dn = b_chg & cnt.b;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dir_reg <= 1'b1;
    end else if (cnt.quad_en && q_up) begin
      dir_reg <= 1'b1;
    end else if (cnt.quad_en && q_dn) begin
      dir_reg <= 1'b0;
    end
  end

  assign cnt.quad_up = dir_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_quad_every_edge: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (cnt.quad_en && (a_chg ^ b_chg)) |-> (cnt.up ^ cnt.dn))
    else $error("quadrature edge without single count");
  chk_quad_dir_track: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (cnt.quad_en && cnt.dn) |=> !cnt.quad_up)
    else $error("direction not following down count");
endmodule
`default_nettype wire

//--- mmuc_top.sv
`include "mmuc_regs.svh"
`default_nettype none
module mmuc_top
  import mmuc_pkg::*;
#(
  parameter int COUNT_W = 24
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cd,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic count_a,
  input wire logic count_b,
  input wire logic gate_or_clear_pin_n,
  input wire logic external_load_pin_n,
  output logic overflow_out,
  output logic underflow_out
);
  generate
    if (COUNT_W != 24) begin : g_bad_width
      $error("count width must be 24 for six-digit modes");
    end
  endgenerate

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_pipe_reg;
  logic rst_sync_n;
  logic [15:0] pin_meta_reg;
  logic [15:0] pin_sync_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Idle pin levels, so no false strobe or count edge follows reset
      pin_meta_reg <= 16'hfb00;
      pin_sync_reg <= 16'hfb00;
    end else begin
      pin_meta_reg <= {cs_n, rd_n, wr_n, external_load_pin_n, gate_or_clear_pin_n, cd, count_b, count_a, data_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic cs_s_n, rd_s_n, wr_s_n, load_s_n, gate_s_n, cd_s, a_s, b_s;
  logic [7:0] data_s;
  assign {cs_s_n, rd_s_n, wr_s_n, load_s_n, gate_s_n, cd_s, b_s, a_s, data_s} = pin_sync_reg;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [5:0] input_control;
  logic [5:0] output_counter_control;
  logic [1:0] quadrature_control;
  mmuc_count_t preset_value;
  mmuc_count_t count_snapshot;
  mmuc_count_t main_count;
  logic [4:0] counter_status;
  logic [1:0] byte_ptr_reg;
  logic underflow_toggle, overflow_toggle, match_toggle, sign_reg;
  logic once_done_reg, cmp_armed_reg, match_reg, cy_reg, bw_reg;
  logic wr_d_n, rd_d_n, cs_hold_n, cd_hold;
  logic [7:0] data_hold;
  logic load_d_n;

  // ----------------------------------------
  // Bus strobes
  // ----------------------------------------
  // Address and data are captured while the strobe is low and held once it rises, so a late change
  // at the trailing edge cannot corrupt the access
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_d_n <= 1'b1;
      rd_d_n <= 1'b1;
      load_d_n <= 1'b1;
      cs_hold_n <= 1'b1;
      cd_hold <= 1'b0;
      data_hold <= 8'h00;
    end else begin
      wr_d_n <= wr_s_n;
      rd_d_n <= rd_s_n;
      load_d_n <= load_s_n;
      if (!wr_s_n || !rd_s_n) begin
        cs_hold_n <= cs_s_n;
        cd_hold <= cd_s;
        data_hold <= data_s;
      end
    end
  end

  logic wr_end, rd_end, ctl_wr, dat_wr, dat_rd;
  mmuc_sel_e sel;
  assign wr_end = wr_s_n & ~wr_d_n & ~cs_hold_n;
  assign rd_end = rd_s_n & ~rd_d_n & ~cs_hold_n;
  assign ctl_wr = wr_end & cd_hold;
  assign dat_wr = wr_end & ~cd_hold;
  assign dat_rd = rd_end & ~cd_hold;
  assign sel = mmuc_sel_e'(data_hold[`MMUC_SEL_HI:`MMUC_SEL_LO]);

  logic mc_wr, ic_wr, mreset, load_req, latch_req, clear_req, ptr_clr;
  logic step_up, step_dn, ext_load;
  assign mc_wr = ctl_wr & (sel == MMUC_SEL_MASTER);
  assign ic_wr = ctl_wr & (sel == MMUC_SEL_INPUT);
  assign mreset = mc_wr & data_hold[`MMUC_MC_MRESET];
  assign ext_load = ~load_s_n & load_d_n;
  assign load_req = ~mreset & ((mc_wr & data_hold[`MMUC_MC_LOAD]) | (ext_load & ~input_control[`MMUC_IC_LOAD_ROLE]));
  assign latch_req = ~mreset & ((mc_wr & data_hold[`MMUC_MC_LATCH]) | (ext_load & input_control[`MMUC_IC_LOAD_ROLE]));
  assign clear_req = ~gate_s_n & ~input_control[`MMUC_IC_GATE_ROLE];
  assign ptr_clr = mc_wr & data_hold[`MMUC_MC_PTR_CLR];
  assign step_up = ic_wr & data_hold[`MMUC_IC_STEP_UP];
  assign step_dn = ic_wr & data_hold[`MMUC_IC_STEP_DN];

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset) begin
      input_control <= `MMUC_CTL_RST;
      output_counter_control <= `MMUC_CTL_RST;
      quadrature_control <= 2'h0;
    end else if (ctl_wr) begin
      case (sel)
        MMUC_SEL_INPUT: input_control <= data_hold[5:0];
        MMUC_SEL_OUTCNT: output_counter_control <= data_hold[5:0];
        MMUC_SEL_QUAD: quadrature_control <= data_hold[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Count decoder
  // ----------------------------------------
  mmuc_cnt_if cnt_bus ();
  logic quad_en, ab_en;
  assign quad_en = quadrature_control[`MMUC_QC_EN0] & quadrature_control[`MMUC_QC_EN1];
  assign ab_en = input_control[`MMUC_IC_AB_EN] & (~input_control[`MMUC_IC_GATE_ROLE] | ~gate_s_n);
  assign cnt_bus.a = a_s;
  assign cnt_bus.b = b_s;
  assign cnt_bus.quad_en = quad_en;
  assign cnt_bus.dir_mode = input_control[`MMUC_IC_DIRMODE];

  mmuc_count_decode u_decode (
    .sys_clk(sys_clk),
    .rst_sync_n(rst_sync_n),
    .cnt(cnt_bus.dec)
  );

  // ----------------------------------------
  // Counting arithmetic
  // ----------------------------------------
  function automatic mmuc_count_t bcd_step(input mmuc_count_t v, input mmuc_count_t lim, input logic up);
    mmuc_count_t r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (c && up) begin
        if (v[i*4+:4] >= lim[i*4+:4]) r[i*4+:4] = 4'h0;
        else begin
          r[i*4+:4] = v[i*4+:4] + 4'h1;
          c = 1'b0;
        end
      end else if (c) begin
        if (v[i*4+:4] == 4'h0) r[i*4+:4] = lim[i*4+:4];
        else begin
          r[i*4+:4] = v[i*4+:4] - 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  mmuc_code_e code;
  mmuc_count_t top_val, lim, count_next;
  logic up_evt, dn_evt, cy_evt, bw_evt, divn;
  assign code = output_counter_control[`MMUC_OC_CLOCK] ? MMUC_CODE_CLOCK :
                output_counter_control[`MMUC_OC_BCD] ? MMUC_CODE_BCD : MMUC_CODE_BIN;
  assign divn = output_counter_control[`MMUC_OC_DIVN];
  assign lim = (code == MMUC_CODE_CLOCK) ? `MMUC_CLOCK_LIM : `MMUC_BCD_MAX;
  always_comb begin
    case (code)
      MMUC_CODE_BCD: top_val = `MMUC_BCD_MAX;
      MMUC_CODE_CLOCK: top_val = `MMUC_CLOCK_MAX;
      default: top_val = `MMUC_BIN_MAX;
    endcase
  end
  // Opposite counts in one cycle cancel; single-cycle mode stops both
  assign up_evt = ((cnt_bus.up & ab_en) | step_up) & ~((cnt_bus.dn & ab_en) | step_dn) & ~once_done_reg;
  assign dn_evt = ((cnt_bus.dn & ab_en) | step_dn) & ~((cnt_bus.up & ab_en) | step_up) & ~once_done_reg;
  assign cy_evt = up_evt & (main_count == (divn ? preset_value : top_val));
  assign bw_evt = dn_evt & (main_count == 24'h000000);

  always_comb begin
    count_next = main_count;
    if (cy_evt) count_next = 24'h000000;
    else if (bw_evt) count_next = divn ? preset_value : top_val;
    else if (up_evt || dn_evt) begin
      if (code == MMUC_CODE_BIN) count_next = up_evt ? main_count + 24'h000001 : main_count - 24'h000001;
      else count_next = bcd_step(main_count, lim, up_evt);
    end
  end

  // ----------------------------------------
  // Counter, preset, snapshot
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset || clear_req) begin
      main_count <= 24'h000000;
    end else if (load_req) begin
      main_count <= preset_value;
    end else begin
      main_count <= count_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset) begin
      preset_value <= `MMUC_PRESET_RST;
    end else if (dat_wr) begin
      preset_value[byte_ptr_reg*8+:8] <= data_hold;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset) begin
      count_snapshot <= 24'h000000;
    end else if (latch_req) begin
      count_snapshot <= main_count;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset || ptr_clr) begin
      byte_ptr_reg <= 2'h0;
    end else if (dat_wr || dat_rd) begin
      byte_ptr_reg <= (byte_ptr_reg == `MMUC_LAST_BYTE) ? 2'h0 : byte_ptr_reg + 2'h1;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic match_now;
  assign match_now = cmp_armed_reg & (main_count == preset_value);
  // Events win over a clear written in the same cycle
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset) begin
      underflow_toggle <= 1'b0;
      overflow_toggle <= 1'b0;
      sign_reg <= 1'b0;
    end else begin
      if (bw_evt) underflow_toggle <= ~underflow_toggle;
      else if (mc_wr && data_hold[`MMUC_MC_TOG_CLR]) underflow_toggle <= 1'b0;
      if (cy_evt) overflow_toggle <= ~overflow_toggle;
      else if (mc_wr && data_hold[`MMUC_MC_TOG_CLR]) overflow_toggle <= 1'b0;
      if (clear_req) sign_reg <= 1'b0;
      else if (bw_evt) sign_reg <= 1'b1;
      else if (cy_evt || (mc_wr && data_hold[`MMUC_MC_TOG_CLR])) sign_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset) begin
      match_toggle <= 1'b0;
      match_reg <= 1'b0;
      cmp_armed_reg <= 1'b1;
    end else begin
      match_reg <= match_now;
      if (match_now && !match_reg) match_toggle <= ~match_toggle;
      else if (mc_wr && data_hold[`MMUC_MC_MATCH_CLR]) match_toggle <= 1'b0;
      if (load_req) cmp_armed_reg <= 1'b0;
      else if (up_evt || dn_evt) cmp_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n || mreset || clear_req || load_req) begin
      once_done_reg <= 1'b0;
    end else if (output_counter_control[`MMUC_OC_ONCE] && (cy_evt || bw_evt)) begin
      once_done_reg <= 1'b1;
    end
  end

  assign counter_status = {quad_en ? cnt_bus.quad_up : 1'b1, sign_reg, match_toggle, overflow_toggle,
                           underflow_toggle};

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  mmuc_route_e route;
  assign route = mmuc_route_e'(output_counter_control[`MMUC_OC_ROUTE_HI:`MMUC_OC_ROUTE_LO]);
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cy_reg <= 1'b0;
      bw_reg <= 1'b0;
      overflow_out <= 1'b1;
      underflow_out <= 1'b1;
      data_out <= 8'h00;
    end else begin
      cy_reg <= cy_evt;
      bw_reg <= bw_evt;
      case (route)
        MMUC_ROUTE_TOGGLE: {overflow_out, underflow_out} <= {overflow_toggle, underflow_toggle};
        MMUC_ROUTE_PULSE_HI: {overflow_out, underflow_out} <= {cy_reg, bw_reg};
        MMUC_ROUTE_COMPARE: {overflow_out, underflow_out} <= {~match_reg, match_toggle};
        default: {overflow_out, underflow_out} <= {~cy_reg, ~bw_reg};
      endcase
      data_out <= cd_s ? {3'h0, counter_status} : count_snapshot[byte_ptr_reg*8+:8];
    end
  end
  // Bus driven only while selected and reading
  assign data_oe = rst_sync_n & ~cs_s_n & ~rd_s_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_load;
    load_req && !clear_req;
  endsequence
  sequence s_armed_again;
    !match_now ##1 (!match_now)[*1];
  endsequence

  chk_under_toggle: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (bw_evt && !mreset) |=> (underflow_toggle != $past(underflow_toggle)))
    else $error("underflow toggle missed");
  chk_sign_borrow: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (bw_evt && !mreset && !clear_req) |=> sign_reg ##1
    (sign_reg || $past(cy_evt) || $past(clear_req) || $past(mc_wr)))
    else $error("sign not set on borrow");
  chk_up_forced: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    !quad_en |-> counter_status[`MMUC_ST_UP])
    else $error("direction bit not forced outside quadrature");
  chk_status_read: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (data_oe && cd_s) |=> (data_out == {3'h0, $past(counter_status)}))
    else $error("status read mismatch");
  chk_load_value: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (s_load and (!mreset)) |=> (main_count == $past(preset_value)))
    else $error("load did not copy preset");
  chk_snapshot_take: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    latch_req |=> (count_snapshot == $past(main_count)))
    else $error("snapshot not taken");
  chk_master_reset: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    mreset |=> (main_count == 24'h000000 && preset_value == `MMUC_PRESET_RST && input_control == `MMUC_CTL_RST))
    else $error("master reset incomplete");
  chk_once_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (once_done_reg && !load_req && !clear_req && !mreset) |=> $stable(main_count))
    else $error("counting after single cycle end");
  chk_load_no_match: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    (s_load and (!mreset)) ##1 (!up_evt && !dn_evt) |-> s_armed_again)
    else $error("compare fired after load");
  chk_ptr_wrap: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    byte_ptr_reg <= `MMUC_LAST_BYTE)
    else $error("byte pointer out of range");
endmodule
`default_nettype wire

//--- mmuc_host.sv
`default_nettype none
// ----------------------------------------
// Bus master model
// ----------------------------------------
module mmuc_host (
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic cd,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel_n = 1'b0;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    cd = 1'b1;
    data_in = 8'h00;
  end
  // Strobes held low 4 cycles (5 on reads) and high 4 after, wider than the pin synchronisers need
  task automatic put(input logic c, input logic [7:0] d);
    @(negedge sys_clk);
    cs_n = sel_n;
    cd = c;
    data_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    data_in = ~d; // Released bus must not keep the old value
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic get(input logic c, output logic [7:0] d, output logic oe);
    @(negedge sys_clk);
    cs_n = 1'b0;
    cd = c;
    rd_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    d = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- mmuc_top_tb.sv
`default_nettype none
module mmuc_top_tb;
  import mmuc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic count_a = 1'b1;
  logic count_b = 1'b1;
  logic clr_n = 1'b1;
  logic load_n = 1'b1;
  logic cs_n, rd_n, wr_n, cd, data_oe, overflow_out, underflow_out, oe;
  logic [7:0] data_in, data_out, d;
  int miscompares = 0;
  int checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  mmuc_host HOST (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .cd(cd), .data_in(data_in));
  mmuc_top #(.COUNT_W(24)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .cd(cd), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .count_a(count_a), .count_b(count_b),
    .gate_or_clear_pin_n(clr_n), .external_load_pin_n(load_n), .overflow_out(overflow_out),
    .underflow_out(underflow_out));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic rd_chk(input logic c, input logic [7:0] exp, input string msg);
    HOST.get(c, d, oe);
    chk(d, exp, msg);
    chk({7'h00, oe}, 8'h01, "bus enable");
  endtask
  // Pins idle high, so the rising edge ends each pulse and host steps see A and B high
  task automatic pulse(input int n, input logic on_b);
    repeat (n) begin
      @(negedge sys_clk);
      if (on_b) count_b = 1'b0; else count_a = 1'b0;
      repeat (4) @(negedge sys_clk);
      count_a = 1'b1;
      count_b = 1'b1;
      repeat (4) @(negedge sys_clk);
    end
  endtask
  // Four A,B level pairs, each held four cycles
  task automatic quad(input logic [7:0] seq);
    for (int i = 7; i > 0; i -= 2) begin
      @(negedge sys_clk);
      count_a = seq[i];
      count_b = seq[i-1];
      repeat (3) @(negedge sys_clk);
    end
  endtask
  task automatic final_report();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(1'b1, 8'h10, "status after reset");
    chk({6'h00, overflow_out, underflow_out}, 8'h03, "outputs idle");
    $display("test reset done");
  endtask
  task automatic t_preset();
    HOST.put(1'b1, 8'h01);
    HOST.put(1'b0, 8'h56);
    HOST.put(1'b0, 8'h34);
    HOST.put(1'b0, 8'h12);
    HOST.put(1'b1, 8'h08);
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h56, "snapshot low");
    rd_chk(1'b0, 8'h34, "snapshot mid");
    rd_chk(1'b0, 8'h12, "snapshot high");
    rd_chk(1'b1, 8'h10, "no match after load");
    $display("test preset done");
  endtask
  task automatic t_step();
    HOST.put(1'b1, 8'h20);
    rd_chk(1'b1, 8'h10, "status after master reset");
    HOST.put(1'b1, 8'h44);
    rd_chk(1'b1, 8'h1d, "after underflow");
    HOST.put(1'b1, 8'h42);
    rd_chk(1'b1, 8'h17, "after overflow");
    HOST.put(1'b1, 8'h04);
    rd_chk(1'b1, 8'h14, "toggles cleared");
    HOST.put(1'b1, 8'h10);
    rd_chk(1'b1, 8'h10, "match cleared");
    $display("test step done");
  endtask
  task automatic t_pins();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h48);
    pulse(5, 1'b0);
    pulse(2, 1'b1);
    HOST.put(1'b1, 8'h49);
    count_b = 1'b1;
    pulse(2, 1'b0);
    HOST.put(1'b1, 8'h41);
    pulse(1, 1'b0);
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h01, "pin count");
    $display("test pins done");
  endtask
  task automatic t_code();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h91);
    HOST.put(1'b1, 8'h44);
    chk({6'h00, overflow_out, underflow_out}, 8'h01, "toggle route");
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h99, "bcd wrap");
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h89);
    HOST.put(1'b1, 8'h44);
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h59, "clock seconds");
    rd_chk(1'b0, 8'h59, "clock minutes");
    rd_chk(1'b0, 8'h23, "clock hours");
    $display("test code done");
  endtask
  task automatic t_cmp();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'hb0);
    HOST.sel_n = 1'b1;
    HOST.put(1'b1, 8'h44);
    HOST.sel_n = 1'b0;
    chk({6'h00, overflow_out, underflow_out}, 8'h02, "deselected write");
    HOST.put(1'b1, 8'h44);
    chk({6'h00, overflow_out, underflow_out}, 8'h01, "compare outputs");
    HOST.put(1'b1, 8'ha0);
    chk({6'h00, overflow_out, underflow_out}, 8'h00, "high pulse idle");
    $display("test compare done");
  endtask
  task automatic t_once();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h01);
    HOST.put(1'b0, 8'h02);
    HOST.put(1'b0, 8'h00);
    HOST.put(1'b0, 8'h00);
    HOST.put(1'b1, 8'h86);
    HOST.put(1'b1, 8'h08);
    HOST.put(1'b1, 8'h42);
    HOST.put(1'b1, 8'h42);
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h00, "single cycle stop");
    rd_chk(1'b1, 8'h12, "divide carry");
    $display("test once done");
  endtask
  task automatic t_gate();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h78);
    pulse(1, 1'b0);
    clr_n = 1'b0;
    pulse(2, 1'b0);
    clr_n = 1'b1;
    load_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    load_n = 1'b1;
    HOST.put(1'b1, 8'h01);
    rd_chk(1'b0, 8'h02, "gated count");
    HOST.put(1'b1, 8'h48);
    load_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    load_n = 1'b1;
    HOST.put(1'b1, 8'h42);
    HOST.put(1'b1, 8'h44);
    clr_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    clr_n = 1'b1;
    rd_chk(1'b1, 8'h17, "clear pin");
    $display("test gate done");
  endtask
  task automatic t_quad();
    HOST.put(1'b1, 8'h20);
    HOST.put(1'b1, 8'h48);
    HOST.put(1'b1, 8'hc3);
    quad(8'h4b);
    quad(8'h4b);
    quad(8'h87);
    HOST.put(1'b1, 8'h03);
    rd_chk(1'b0, 8'h04, "quad count");
    rd_chk(1'b1, 8'h00, "quad direction");
    HOST.put(1'b1, 8'hc1);
    rd_chk(1'b1, 8'h10, "quad off");
    $display("test quad done");
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_preset();
    t_step();
    t_pins();
    t_code();
    t_cmp();
    t_once();
    t_gate();
    t_quad();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
